// file: susc_pkg.sv
package susc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CLOCK_SOURCE_SELECT_ADDR = 8'ha9;
    localparam logic [7:0] CLOCK_STATUS_ADDR = 8'hab;
    localparam logic [7:0] CLOCK_ACTIVE_ADDR = 8'hac;
    localparam logic [7:0] CLOCK_SOURCE_SELECT_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SYS_FIELD_LSB = 0;
    localparam int USB_FIELD_LSB = 4;
    localparam int STAT_XTAL_BIT = 0;
    localparam int STAT_SYS_BUSY_BIT = 1;
    localparam int STAT_USB_BUSY_BIT = 2;

    // ------------------------------------------------------------
    // Source codes
    // ------------------------------------------------------------
    localparam logic [2:0] SYS_INT_OSC = 3'h0;
    localparam logic [2:0] SYS_EXT_OSC = 3'h1;
    localparam logic [2:0] SYS_MULT_HALF = 3'h2;
    localparam logic [2:0] SYS_MULT_FULL = 3'h3;
    localparam logic [2:0] SYS_LF_OSC = 3'h4;
    localparam logic [2:0] USB_MULT = 3'h0;
    localparam logic [2:0] USB_INT_HALF = 3'h1;
    localparam logic [2:0] USB_EXT = 3'h2;
    localparam logic [2:0] USB_EXT_HALF = 3'h3;
    localparam logic [2:0] USB_EXT_THIRD = 3'h4;
    localparam logic [2:0] USB_EXT_QUARTER = 3'h5;
    localparam int SYS_SOURCES = 5;
    localparam int USB_SOURCES = 6;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int SWITCH_DEAD_NS = 100;
    localparam int SWITCH_DEAD_RAW = (SWITCH_DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SWITCH_DEAD_CYCLES = (SWITCH_DEAD_RAW < 1) ? 1 : SWITCH_DEAD_RAW;

    typedef enum logic [0:0] {
        SUSC_RUN = 1'b0,
        SUSC_GAP = 1'b1
    } susc_sw_state_t;

endpackage : susc_pkg

// file: susc_switch.sv
`timescale 1ns/1ns
`default_nettype none
module susc_switch
    import susc_pkg::*;
#(
    parameter int N_SRC = 5,
    parameter int DEAD = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request
    input wire logic req,
    input wire logic [2:0] req_idx,
    // Gates and state
    output logic [N_SRC-1:0] gate,
    output logic [2:0] active_idx,
    output logic busy
);

    localparam int CNT_W = $clog2(DEAD + 1) + 1;
    localparam int SW_MAX = DEAD + 2;

    susc_sw_state_t state;
    susc_sw_state_t next_state;
    logic [2:0] target;
    logic [2:0] next_target;
    logic [2:0] next_active_idx;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [N_SRC-1:0] next_gate;

    // ------------------------------------------------------------
    // Break before make
    // ------------------------------------------------------------
    // All gates stay off for DEAD cycles so the old source is fully
    // stopped before the new one starts; no runt pulse can leak out.
    always_comb begin
        next_state = state;
        next_target = target;
        next_active_idx = active_idx;
        next_cnt = cnt;
        next_gate = gate;
        case (state)
            SUSC_RUN: begin
                if (req && req_idx != active_idx) begin // R7
                    next_state = SUSC_GAP;
                    next_target = req_idx;
                    next_cnt = CNT_W'(DEAD - 1);
                    next_gate = '0; // R14
                end
            end
            SUSC_GAP: begin
                // A late request only retargets, the gap is not restarted
                if (req) begin
                    next_target = req_idx;
                end
                if (cnt == '0) begin
                    next_state = SUSC_RUN;
                    next_active_idx = req ? req_idx : target;
                    next_gate = N_SRC'(1) << (req ? req_idx : target);
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            default: begin
                next_state = SUSC_RUN;
                next_gate = N_SRC'(1) << active_idx;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SUSC_RUN;
            target <= 3'h0;
            active_idx <= 3'h0; // R15
            cnt <= '0;
            gate <= N_SRC'(1);
        end else begin
            state <= next_state;
            target <= next_target;
            active_idx <= next_active_idx;
            cnt <= next_cnt;
            gate <= next_gate;
        end
    end

    assign busy = (state == SUSC_GAP);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [7:0] gap_len;

    always_ff @(posedge clk) begin
        if (rst) begin
            gap_len <= 8'h00;
        end else if (gate == '0) begin
            gap_len <= (gap_len == 8'hff) ? gap_len : gap_len + 8'h01;
        end else begin
            gap_len <= 8'h00;
        end
    end

    sequence s_switch_start;
        state == SUSC_RUN && req && req_idx != active_idx;
    endsequence

    sequence s_gate_back;
        ##[1:SW_MAX] (gate != '0 && !busy);
    endsequence

    a_gate_at_most_one: assert property (@(posedge clk) disable iff (rst) // R14
        $onehot0(gate))
        else $error("two clock gates open at once");

    a_dead_time_kept: assert property (@(posedge clk) disable iff (rst) // R14
        ($past(gate) == '0 && gate != '0) |-> gap_len >= 8'(DEAD))
        else $error("gate opened before the dead time ran out");

    a_switch_finishes: assert property (@(posedge clk) disable iff (rst) // R7
        s_switch_start |-> s_gate_back)
        else $error("clock switch did not complete in time");

endmodule : susc_switch
`default_nettype wire

// file: susc_top.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [R1] Internal oscillator may be selected at once after enabling, no settle wait.
// [R2] Crystal-valid flag reads 1 once the external oscillator has settled.
// [R3] Software waits at least 1 ms after enabling crystal before reading flag.
// [R4] System select codes: internal, external, multiplier half, multiplier, low-frequency.
// [R5] Full multiplier as system clock only on 48 MHz variants.
// [R6] External oscillator may still feed USB while internal drives system.
// [R7] System clock switches on the fly; software picks only settled sources.
// [R8] Software sets flash read timing bit above 25 MHz, clears it otherwise.
// [R9] USB select codes: multiplier, internal/2, external, external/2, /3, /4.
// [R10] Software sets USB clock to 48 MHz full speed, 6 MHz low speed.
// [R11] Bits 7 and 3 of the select register read zero, ignore writes.
// [R12] Multiplier from internal oscillator for USB needs clock recovery enabled.
// [R13] Multiplier bring-up: clear, select input, enable, wait 5 us, init, poll.
// [R14] Source switches are glitch free; reserved codes never give undefined clocks.
// [R15] After reset both select fields are zero.
module susc_top
    import susc_pkg::*;
#(
    parameter bit MULT48_VARIANT = 1'b1,
    parameter int DEAD = SWITCH_DEAD_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Oscillator status pin
    input wire logic ext_osc_settled,
    // System clock gating, one gate per source code
    output logic [SYS_SOURCES-1:0] sys_clk_gate,
    output logic [2:0] sys_src_active,
    output logic sys_switching,
    // USB clock gating, one gate per source code
    output logic [USB_SOURCES-1:0] usb_clk_gate,
    output logic [2:0] usb_src_active,
    output logic usb_switching,
    // Status
    output logic crystal_valid_flag
);

    // ------------------------------------------------------------
    // Code legality
    // ------------------------------------------------------------
    function automatic logic sys_code_ok(input logic [2:0] code);
        logic ok;
        ok = (code <= SYS_LF_OSC); // R4
        if (code == SYS_MULT_FULL && !MULT48_VARIANT) begin
            ok = 1'b0; // R5
        end
        return ok;
    endfunction : sys_code_ok

    function automatic logic usb_code_ok(input logic [2:0] code);
        return code <= USB_EXT_QUARTER; // R9
    endfunction : usb_code_ok

    // ------------------------------------------------------------
    // Select register
    // ------------------------------------------------------------
    logic [2:0] sys_clk_src;
    logic [2:0] usb_clk_src;
    logic [2:0] next_sys_clk_src;
    logic [2:0] next_usb_clk_src;
    logic sel_wr;
    logic [2:0] wr_sys_code;
    logic [2:0] wr_usb_code;

    assign sel_wr = reg_wr && (reg_addr == CLOCK_SOURCE_SELECT_ADDR);
    assign wr_sys_code = reg_wdata[SYS_FIELD_LSB +: 3];
    assign wr_usb_code = reg_wdata[USB_FIELD_LSB +: 3];

    // The fields keep whatever software wrote, reserved codes too, so a
    // read shows the request; only legal codes move the clock gates.
    always_comb begin
        next_sys_clk_src = sys_clk_src;
        next_usb_clk_src = usb_clk_src;
        if (sel_wr) begin
            next_sys_clk_src = wr_sys_code;
            next_usb_clk_src = wr_usb_code;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sys_clk_src <= CLOCK_SOURCE_SELECT_RESET[SYS_FIELD_LSB +: 3]; // R15
            usb_clk_src <= CLOCK_SOURCE_SELECT_RESET[USB_FIELD_LSB +: 3]; // R15
        end else begin
            sys_clk_src <= next_sys_clk_src;
            usb_clk_src <= next_usb_clk_src;
        end
    end

    // ------------------------------------------------------------
    // Switch requests
    // ------------------------------------------------------------
    logic sys_req;
    logic usb_req;

    // The internal oscillator needs no settle wait, so its request goes
    // straight through like any other legal code.
    assign sys_req = sel_wr && sys_code_ok(wr_sys_code); // R1
    assign usb_req = sel_wr && usb_code_ok(wr_usb_code); // R14

    susc_switch #(
        .N_SRC(SYS_SOURCES),
        .DEAD(DEAD)
    ) u_sys_switch (
        .clk(clk),
        .rst(rst),
        .req(sys_req),
        .req_idx(wr_sys_code),
        .gate(sys_clk_gate),
        .active_idx(sys_src_active),
        .busy(sys_switching)
    );

    // Separate sequencer: USB may run from the external oscillator
    // whatever drives the system clock.
    susc_switch #(
        .N_SRC(USB_SOURCES),
        .DEAD(DEAD)
    ) u_usb_switch ( // R6
        .clk(clk),
        .rst(rst),
        .req(usb_req),
        .req_idx(wr_usb_code),
        .gate(usb_clk_gate),
        .active_idx(usb_src_active),
        .busy(usb_switching)
    );

    // ------------------------------------------------------------
    // Crystal valid
    // ------------------------------------------------------------
    logic settled_meta;
    logic next_crystal_valid_flag;

    // Only the second stage is read. The flag is a level and follows the
    // oscillator; a false early reading is software's to avoid.
    always_comb begin
        next_crystal_valid_flag = settled_meta; // R2
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            settled_meta <= 1'b0;
            crystal_valid_flag <= 1'b0;
        end else begin
            settled_meta <= ext_osc_settled;
            crystal_valid_flag <= next_crystal_valid_flag;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] next_reg_rdata;

    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                CLOCK_SOURCE_SELECT_ADDR: begin
                    // Bits 7 and 3 are not stored and read as zero
                    next_reg_rdata = {1'b0, usb_clk_src, 1'b0, sys_clk_src}; // R11
                end
                CLOCK_STATUS_ADDR: begin
                    next_reg_rdata[STAT_XTAL_BIT] = crystal_valid_flag;
                    next_reg_rdata[STAT_SYS_BUSY_BIT] = sys_switching;
                    next_reg_rdata[STAT_USB_BUSY_BIT] = usb_switching;
                end
                CLOCK_ACTIVE_ADDR: begin
                    next_reg_rdata = {1'b0, usb_src_active, 1'b0, sys_src_active};
                end
                default: begin
                    next_reg_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int SETTLE_MAX = 8;

    sequence s_sel_read;
        reg_rd && reg_addr == CLOCK_SOURCE_SELECT_ADDR;
    endsequence

    sequence s_sel_quiet;
        (!sel_wr)[*5];
    endsequence

    a_reserved_bits_zero: assert property (@(posedge clk) disable iff (rst) // R11
        s_sel_read |=> (reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0))
        else $error("unused select bits did not read zero");

    a_sel_readback: assert property (@(posedge clk) disable iff (rst) // R11
        (sel_wr ##1 s_sel_read) |=>
            reg_rdata == ($past(reg_wdata, 2) & 8'h77))
        else $error("select register read back wrong value");

    a_reset_state: assert property (@(posedge clk) // R15
        rst |=> (sys_clk_src == 3'h0 && usb_clk_src == 3'h0
            && sys_clk_gate == SYS_SOURCES'(1)
            && usb_clk_gate == USB_SOURCES'(1)))
        else $error("clock select not at internal and multiplier after reset");

    a_crystal_follows: assert property (@(posedge clk) disable iff (rst) // R2
        ext_osc_settled[*3] |=> crystal_valid_flag)
        else $error("crystal valid flag missed a settled oscillator");

    a_sys_decode: assert property (@(posedge clk) disable iff (rst) // R4
        (sys_req ##1 s_sel_quiet) |->
            (sys_src_active == $past(wr_sys_code, 5)
            && sys_clk_gate == SYS_SOURCES'(1) << $past(wr_sys_code, 5)))
        else $error("system clock not on the selected source");

    a_usb_decode: assert property (@(posedge clk) disable iff (rst) // R9
        (usb_req ##1 s_sel_quiet) |->
            (usb_src_active == $past(wr_usb_code, 5)
            && usb_clk_gate == USB_SOURCES'(1) << $past(wr_usb_code, 5)))
        else $error("USB clock not on the selected source");

    a_int_osc_fast: assert property (@(posedge clk) disable iff (rst) // R1
        (sys_req && wr_sys_code == SYS_INT_OSC && !sys_switching)
            |-> ##[1:SETTLE_MAX] sys_clk_gate[0])
        else $error("internal oscillator not selected promptly");

    a_reserved_ignored: assert property (@(posedge clk) disable iff (rst) // R14
        (sel_wr && !sys_code_ok(wr_sys_code) && !sys_switching)
            |=> ($stable(sys_src_active) && !sys_switching))
        else $error("reserved system code moved the clock");

    a_mult_variant: assert property (@(posedge clk) disable iff (rst) // R5
        !MULT48_VARIANT |-> sys_src_active != SYS_MULT_FULL)
        else $error("full multiplier used on a variant without it");

    a_usb_independent: assert property (@(posedge clk) disable iff (rst) // R6
        (sel_wr && !usb_code_ok(wr_usb_code) && sys_req) |=> $stable(usb_src_active))
        else $error("USB source moved on a system-only change");

endmodule : susc_top
`default_nettype wire

// file: susc_osc_model.sv
`timescale 1ns/1ns
`default_nettype none
module susc_osc_model #(
    parameter int FAST = 4,
    parameter int SLOW = 15000,
    parameter int EN_MIN = 101
) (
    // Clock
    input wire logic clk,
    // Control from the bench
    input wire logic osc_en,
    input wire logic slow,
    // Oscillator status pin
    output logic settled,
    // Multiplier bring-up from the bench
    input wire logic mult_en,
    input wire logic mult_init,
    input wire logic clk_recovery,
    output logic mult_ready
);
    int count = 0;
    int en_count = 0;

    initial settled = 1'b0;
    initial mult_ready = 1'b0;

    // ------------------------------------------------------------
    // Start-up time
    // ------------------------------------------------------------
    // A crystal needs a start-up time before it is usable, so the pin stays low
    // for a fast or a slow count after enabling and drops as soon as it is off
    always @(posedge clk) begin
        if (!osc_en) begin
            count <= 0;
            settled <= 1'b0;
        end else if (count >= (slow ? SLOW : FAST)) begin
            settled <= 1'b1;
        end else begin
            count <= count + 1;
        end
    end

    // ------------------------------------------------------------
    // Multiplier
    // ------------------------------------------------------------
    // An init before the enable has stood long enough, or without clock
    // recovery on the internal input, leaves the multiplier unready
    always @(posedge clk) begin
        if (!mult_en) begin
            en_count <= 0;
            mult_ready <= 1'b0;
        end else if (!mult_init) begin
            en_count <= (en_count < EN_MIN) ? en_count + 1 : en_count;
        end else if (en_count >= EN_MIN && clk_recovery) begin
            mult_ready <= 1'b1;
        end
    end
endmodule : susc_osc_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
    import susc_pkg::*;
;
    localparam int DEAD_CYC = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic ext_osc_settled;
    logic [SYS_SOURCES-1:0] sys_clk_gate;
    logic [2:0] sys_src_active;
    logic sys_switching;
    logic [USB_SOURCES-1:0] usb_clk_gate;
    logic [2:0] usb_src_active;
    logic usb_switching;
    logic crystal_valid_flag;
    logic osc_en = 1'b0;
    logic osc_slow = 1'b0;
    logic mult_en = 1'b0;
    logic mult_init = 1'b0;
    logic clk_recovery = 1'b0;
    logic mult_ready;
    logic [2:0] nm_sys_active;
    logic [2:0] cur_n = 3'h0;
    logic rd_q = 1'b0;
    logic [7:0] exp_q[$];
    logic [2:0] cur_s = 3'h0;
    logic [2:0] cur_u = 3'h0;
    logic [31:0] rng = 32'h0000_0c3c;
    logic [7:0] rsv[4] = '{8'hff, 8'h65, 8'h76, 8'h63};
    int failures = 0;
    int checks_done = 0;

    always #25 clk = ~clk;

    susc_top #(.MULT48_VARIANT(1'b1), .DEAD(DEAD_CYC)) i_susc_top (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_osc_settled(ext_osc_settled), .sys_clk_gate(sys_clk_gate),
        .sys_src_active(sys_src_active), .sys_switching(sys_switching),
        .usb_clk_gate(usb_clk_gate), .usb_src_active(usb_src_active),
        .usb_switching(usb_switching), .crystal_valid_flag(crystal_valid_flag)
    );

    // Variant without the full multiplier as system clock
    susc_top #(.MULT48_VARIANT(1'b0), .DEAD(DEAD_CYC)) i_susc_top_no48 (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
        .ext_osc_settled(ext_osc_settled), .sys_clk_gate(),
        .sys_src_active(nm_sys_active), .sys_switching(),
        .usb_clk_gate(), .usb_src_active(),
        .usb_switching(), .crystal_valid_flag()
    );

    susc_osc_model i_susc_osc_model (
        .clk(clk), .osc_en(osc_en), .slow(osc_slow), .settled(ext_osc_settled),
        .mult_en(mult_en), .mult_init(mult_init), .clk_recovery(clk_recovery),
        .mult_ready(mult_ready)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // Entered at a rising edge; hold keeps the strobe up for a back-to-back access
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic hold);
        if (!w) begin
            exp_q.push_back(d);
        end
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        if (!hold) begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
        end
    endtask : bus

    // Write a select byte, check the break-before-make gap, the new gates and readback
    task automatic sel(input logic [7:0] d);
        logic sg;
        logic ug;
        sg = (d[2:0] < 3'h5) && (d[2:0] != cur_s);
        ug = (d[6:4] < 3'h6) && (d[6:4] != cur_u);
        @(posedge clk);
        bus(1'b1, CLOCK_SOURCE_SELECT_ADDR, d, 1'b0);
        @(negedge clk);
        check({3'h0, sys_clk_gate}, sg ? 8'h00 : 8'h01 << cur_s, "sys gap");
        check({7'h0, sys_switching}, {7'h0, sg}, "sys busy");
        check({2'h0, usb_clk_gate}, ug ? 8'h00 : 8'h01 << cur_u, "usb gap");
        check({7'h0, usb_switching}, {7'h0, ug}, "usb busy");
        if (sg) begin
            cur_s = d[2:0];
        end
        if (ug) begin
            cur_u = d[6:4];
        end
        if (d[2:0] < 3'h5 && d[2:0] != SYS_MULT_FULL) begin
            cur_n = d[2:0];
        end
        repeat (DEAD_CYC) @(posedge clk);
        @(negedge clk);
        check({3'h0, sys_clk_gate}, 8'h01 << cur_s, "sys gate");
        check({5'h0, sys_src_active}, {5'h0, cur_s}, "sys active");
        check({5'h0, nm_sys_active}, {5'h0, cur_n}, "no48 active");
        check({2'h0, usb_clk_gate}, 8'h01 << cur_u, "usb gate");
        check({5'h0, usb_src_active}, {5'h0, cur_u}, "usb active");
        @(posedge clk);
        bus(1'b0, CLOCK_SOURCE_SELECT_ADDR, d & 8'h77, 1'b1);
        bus(1'b0, CLOCK_ACTIVE_ADDR, {1'b0, cur_u, 1'b0, cur_s}, 1'b0);
    endtask : sel

    // ------------------------------------------------------------
    // Monitor
    // ------------------------------------------------------------
    always @(posedge clk) rd_q <= reg_rd;

    always @(negedge clk) begin
        if (rd_q) begin
            check(reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'h00, "read data");
        end else if (!rst) begin
            check(reg_rdata, 8'h00, "idle read data");
        end
        if (!rst) begin
            check({7'h0, ($countones(sys_clk_gate) > 1 || $countones(usb_clk_gate) > 1)},
                8'h00, "two clock gates open");
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [7:0] a;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({3'h0, sys_clk_gate}, 8'h01, "reset sys gate");
        check({2'h0, usb_clk_gate}, 8'h01, "reset usb gate");
        @(posedge clk);
        bus(1'b0, CLOCK_SOURCE_SELECT_ADDR, 8'h00, 1'b1);
        bus(1'b0, CLOCK_STATUS_ADDR, 8'h00, 1'b1);
        bus(1'b0, CLOCK_ACTIVE_ADDR, 8'h00, 1'b0);
        sel(8'h00);
        // Slow crystal: software waits a full millisecond before trusting the flag
        osc_slow <= 1'b1;
        osc_en <= 1'b1;
        @(posedge clk);
        bus(1'b0, CLOCK_STATUS_ADDR, 8'h00, 1'b0);
        repeat (20000) @(posedge clk);
        bus(1'b0, CLOCK_STATUS_ADDR, 8'h01, 1'b0);
        // Multiplier from the internal oscillator, clock recovery on, before use
        clk_recovery <= 1'b1;
        mult_en <= 1'b1;
        repeat (101) @(posedge clk);
        mult_init <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check({7'h0, mult_ready}, 8'h01, "multiplier ready");
        // Every source code, each different from the one before; external runs USB
        for (int i = 0; i < 6; i++) begin
            sel({1'b0, 3'((i + 1) % 6), 1'b0, 3'((i + 1) % 5)});
        end
        foreach (rsv[k]) begin
            sel(rsv[k]);
        end
        sel(8'h01);
        @(posedge clk);
        // Retarget while the gap of the first write is still open
        bus(1'b1, CLOCK_SOURCE_SELECT_ADDR, {1'b0, cur_u, 4'h2}, 1'b1);
        bus(1'b1, CLOCK_SOURCE_SELECT_ADDR, {1'b0, cur_u, 4'h4}, 1'b0);
        cur_s = 3'h4;
        cur_n = 3'h4;
        @(negedge clk);
        check({3'h0, sys_clk_gate}, 8'h00, "retarget gap");
        @(negedge clk);
        check({3'h0, sys_clk_gate}, 8'h10, "retarget gate");
        // Fast crystal: flag drops when stopped and rises soon after restart
        osc_en <= 1'b0;
        repeat (6) @(posedge clk);
        check({7'h0, crystal_valid_flag}, 8'h00, "flag off");
        osc_slow <= 1'b0;
        osc_en <= 1'b1;
        for (int n = 0; n < 20 && crystal_valid_flag !== 1'b1; n++) begin
            @(posedge clk);
        end
        @(negedge clk);
        check({7'h0, crystal_valid_flag}, 8'h01, "flag on");
        @(posedge clk);
        // Random unmapped accesses and random legal selections
        for (int j = 0; j < 8; j++) begin
            r = rnd();
            a = r[7:0];
            if (a == CLOCK_SOURCE_SELECT_ADDR || a == CLOCK_STATUS_ADDR || a == CLOCK_ACTIVE_ADDR) begin
                a = a ^ 8'h10;
            end
            sel({1'b0, 3'(r[18:16] % 6), 1'b0, 3'(r[22:20] % 5)});
            @(posedge clk);
            bus(1'b1, a, r[15:8], 1'b1);
            bus(1'b0, a, 8'h00, 1'b1);
            bus(1'b1, CLOCK_SOURCE_SELECT_ADDR, {1'b0, cur_u, 1'b0, cur_s}, 1'b1);
            bus(1'b0, CLOCK_SOURCE_SELECT_ADDR, {1'b0, cur_u, 1'b0, cur_s}, 1'b0);
        end
        repeat (4) @(posedge clk);
        test_done();
    end

    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end
endmodule : tb
`default_nettype wire
